// >>> inc/ext_bus_defs.vh
// constants shared by the external memory bus controller
// assumes a 32-bit word-aligned register map and byte addressing
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// register byte offsets
`define OFS_ACCESS_STATE 5'h00
`define OFS_BUS_WIDTH    5'h04
`define OFS_STALL_CTRL   5'h08
`define OFS_BUS_CTRL     5'h0C
`define OFS_STATUS       5'h10

// power-on reset values
`define RST_ACCESS_STATE 8'hFF
`define RST_BUS_WIDTH    8'hFF
`define RST_STALL_CTRL   16'hFFFF
`define RST_BUS_CTRL     4'h0

// bus control field positions
`define BC_STALL_PIN_EN  0
`define BC_BURST_ROM     1
`define BC_BURST_LEN     2
`define BC_BURST_WORDS   3

// request space codes
`define SPACE_MEM        2'h0
`define SPACE_PER        2'h1
`define SPACE_EXT        2'h2

// request size codes
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_LONG        2'h2

// states per access kind
`define STATES_MEM       2'h1
`define STATES_PER       2'h2
`define STATES_TWO       2'h2
`define STATES_THREE     2'h3

// burst ROM space
`define BURST_AREA       3'h0
`define WORD_STEP        24'h00_0002

`endif

// >>> core/ext_bus_ctrl.v
// external memory bus controller: access sequencer and register file
// assumes one 100 MHz clock, an internal requester on the same clock,
// and external memory pins brought in through two-flop synchronisers
//
// Operation
// - every cycle lasts one, two or three states
// - on-chip memory: one state, 16-bit path
// - peripheral registers: two states, 8/16-bit path
// - external: 8/16-bit, 2 or 3 states
// - 8-bit area: upper lane, split words, longs
// - 16-bit area: byte/word, long as two words
// - 16-bit byte: even upper, odd lower lane
// - single read strobe, unused lane ignored
// - per-lane write strobes, unwritten lane floats
// - 8-bit area keeps lower write strobe high
// - zero to three stall states after second
// - stall bits binary, three-state areas only
// - width and state-count bit decoding per area
// - pin stalls follow programmed stalls while low
// - one stall pin enable for all areas
// - power-on: three states, three stalls, pin off
// - manual reset keeps register contents
// - burst area 0, instruction fetches only
// - burst initial cycle sized by area 0 bit
// - burst cycles one or two states, unstalled
// - burst limited to four or eight words
// - burst area 0 always sixteen bits wide
`timescale 1ns/1ps
`include "ext_bus_defs.vh"

module ext_bus_ctrl #(
  parameter [7:0] BUS_WIDTH_INIT = `RST_BUS_WIDTH
) (
  input  wire        CLK_I,
  input  wire        SRST_I,
  input  wire        MANUAL_RST_I,
  input  wire [4:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output reg  [31:0] AVS_READDATA_O,
  output reg         AVS_WAITREQUEST_O,
  input  wire        REQ_I,
  input  wire [1:0]  REQ_SPACE_I,
  input  wire        REQ_PER_WIDE_I,
  input  wire [2:0]  REQ_AREA_I,
  input  wire [23:0] REQ_ADDR_I,
  input  wire [1:0]  REQ_SIZE_I,
  input  wire        REQ_WRITE_I,
  input  wire        REQ_FETCH_I,
  input  wire [31:0] REQ_WDATA_I,
  output reg         REQ_ACK_O,
  output reg  [31:0] REQ_RDATA_O,
  output reg         INT_MEM_STB_O,
  output reg         INT_PER_STB_O,
  output reg         INT_WE_O,
  output reg  [23:0] INT_ADDR_O,
  output reg  [15:0] INT_WDATA_O,
  output reg  [1:0]  INT_LANE_O,
  input  wire [15:0] INT_RDATA_I,
  output reg  [23:0] ADDR_O,
  output reg         READ_STROBE_N_O,
  output reg         UPPER_WRITE_STROBE_N_O,
  output reg         LOWER_WRITE_STROBE_N_O,
  output reg  [15:0] DATA_O,
  output reg  [1:0]  DATA_OE_O,
  input  wire [15:0] DATA_I,
  input  wire        STALL_REQUEST_N_I
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_S1    = 3'h1;
  localparam [2:0] ST_S2    = 3'h2;
  localparam [2:0] ST_SW    = 3'h3;
  localparam [2:0] ST_S3    = 3'h4;
  localparam [2:0] ST_BURST = 3'h5;
  localparam [3:0] BUS_CTRL_INIT = `RST_BUS_CTRL;

  // configuration, loaded with its reset values only by power-on reset
  reg  [7:0]  access_state_q;
  reg  [7:0]  bus_width_q;
  reg  [15:0] stall_ctrl_q;
  reg         stall_pin_enable_q;
  reg         burst_rom_select_q;
  reg         burst_cycle_length_select_q;
  reg         burst_word_count_select_q;

  // synchronisers for pins
  reg  [15:0] din_s1_q;
  reg  [15:0] din_s2_q;
  reg         stall_s1_q;
  reg         stall_s2_q;
  reg         mrst_s1_q;
  reg         mrst_s2_q;

  // sequencer state
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [1:0]  idx_q;
  reg  [1:0]  idx_d;
  reg  [1:0]  wcnt_q;
  reg  [1:0]  wcnt_d;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg         burst_open_q;
  reg  [23:0] next_addr_q;
  reg  [1:0]  space_q;
  reg         pwide_q;
  reg  [2:0]  area_q;
  reg  [23:0] addr_q;
  reg  [1:0]  size_q;
  reg         we_q;
  reg         fetch_q;
  reg  [31:0] wdata_q;

  // combinational helpers
  reg         in_idle;
  reg  [1:0]  s_space;
  reg         s_pwide;
  reg  [2:0]  s_area;
  reg  [23:0] s_addr;
  reg  [1:0]  s_size;
  reg         s_we;
  reg         s_fetch;
  reg  [31:0] s_wdata;
  reg         s_ext;
  reg         s_bsp;
  reg         s_wide;
  reg         s_three;
  reg  [1:0]  s_prog;
  reg  [1:0]  s_states;
  reg  [1:0]  s_last;
  reg         pin_stall;
  reg         fin;
  reg         start;
  reg         done;
  reg         cont;
  reg  [23:0] sub_addr;
  reg         lane_u;
  reg         lane_l;
  reg  [15:0] sub_wdata;
  reg  [4:0]  sh;
  reg  [31:0] shifted;
  reg  [15:0] rin;
  reg  [7:0]  rbyte;
  reg         active;
  reg  [31:0] reg_rdata;

  wire        seq_rst = SRST_I | mrst_s2_q;
  wire        bus_req = AVS_READ_I | AVS_WRITE_I;
  wire        bus_wr  = AVS_WRITE_I & ~AVS_WAITREQUEST_O;

  // pin inputs pass two flops; only the second stage is read
  always @(posedge CLK_I) begin
    din_s1_q   <= DATA_I;
    din_s2_q   <= din_s1_q;
    stall_s1_q <= STALL_REQUEST_N_I;
    stall_s2_q <= stall_s1_q;
    mrst_s1_q  <= MANUAL_RST_I;
    mrst_s2_q  <= mrst_s1_q;
  end

  // request source: live inputs when idle, latched copy afterwards
  always @* begin
    in_idle = (state_q == ST_IDLE);
    s_space = in_idle ? REQ_SPACE_I    : space_q;
    s_pwide = in_idle ? REQ_PER_WIDE_I : pwide_q;
    s_area  = in_idle ? REQ_AREA_I     : area_q;
    s_addr  = in_idle ? REQ_ADDR_I     : addr_q;
    s_size  = in_idle ? REQ_SIZE_I     : size_q;
    s_we    = in_idle ? REQ_WRITE_I    : we_q;
    s_fetch = in_idle ? REQ_FETCH_I    : fetch_q;
    s_wdata = in_idle ? REQ_WDATA_I    : wdata_q;
    s_ext   = (s_space == `SPACE_EXT);
    // area 0 becomes burst space only when selected
    s_bsp   = s_ext && (s_area == `BURST_AREA) &&
              burst_rom_select_q;
    // width bit 0 means 16-bit; burst space ignores it
    if (s_space == `SPACE_MEM)
      s_wide = 1'b1;
    else if (s_space == `SPACE_PER)
      s_wide = s_pwide;
    else
      s_wide = s_bsp | ~bus_width_q[s_area];
    // state-count bit 1 means three states; area 0 bit sizes burst
    s_three = access_state_q[s_area];
    s_prog  = stall_ctrl_q[{s_area, 1'b0} +: 2];
    if (s_space == `SPACE_MEM)
      s_states = `STATES_MEM;
    else if (s_space == `SPACE_PER)
      s_states = `STATES_PER;
    else
      s_states = s_three ? `STATES_THREE : `STATES_TWO;
    // index of the last access in the transfer
    if (s_size == `SIZE_BYTE)
      s_last = 2'h0;
    else if (s_size == `SIZE_WORD)
      s_last = s_wide ? 2'h0 : 2'h1;
    else
      s_last = s_wide ? 2'h1 : 2'h3;
    // the enable is global, not per area
    pin_stall = stall_pin_enable_q & ~stall_s2_q;
  end

  // sequencer next state
  always @* begin
    state_d = state_q;
    idx_d   = idx_q;
    wcnt_d  = wcnt_q;
    fin     = 1'b0;
    start   = 1'b0;
    done    = 1'b0;
    cont    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // ack cycle blocks a second take of the same request
        if (REQ_I && !REQ_ACK_O) begin
          start = 1'b1;
          idx_d = 2'h0;
        end
      end
      ST_S1: begin
        if (s_states == `STATES_MEM)
          fin = 1'b1;
        else
          state_d = ST_S2;
      end
      ST_S2: begin
        if (s_states == `STATES_TWO)
          fin = 1'b1;
        else if (s_prog != 2'h0) begin
          state_d = ST_SW;
          wcnt_d  = s_prog - 2'h1;
        end else if (pin_stall) begin
          state_d = ST_SW;
          wcnt_d  = 2'h0;
        end else
          state_d = ST_S3;
      end
      ST_SW: begin
        // programmed stalls first, then the pin while it stays low
        if (wcnt_q != 2'h0)
          wcnt_d = wcnt_q - 2'h1;
        else if (!pin_stall)
          state_d = ST_S3;
      end
      ST_S3: begin
        fin = 1'b1;
      end
      ST_BURST: begin
        // continuation cycles never look at the stall pin
        if (wcnt_q != 2'h0)
          wcnt_d = wcnt_q - 2'h1;
        else
          fin = 1'b1;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (fin) begin
      if (idx_q == s_last) begin
        state_d = ST_IDLE;
        done    = 1'b1;
      end else begin
        start = 1'b1;
        idx_d = idx_q + 2'h1;
      end
    end
    // address of the access now starting or running
    if (s_wide)
      sub_addr = s_addr + {21'h00_0000, idx_d, 1'b0};
    else
      sub_addr = s_addr + {22'h00_0000, idx_d};
    if (start) begin
      // continuation only inside one aligned block of 4 or 8 words
      cont = s_bsp && s_fetch &&
             (burst_word_count_select_q ? (sub_addr[3:1] != 3'h0) :
                                          (sub_addr[2:1] != 2'h0)) &&
             ((burst_open_q && sub_addr == next_addr_q) ||
              idx_d != 2'h0);
      state_d = cont ? ST_BURST : ST_S1;
      wcnt_d  = (cont && burst_cycle_length_select_q) ? 2'h1 : 2'h0;
    end
  end

  // lane selection and write data of the current access
  always @* begin
    if (!s_wide) begin
      lane_u = 1'b1;
      lane_l = 1'b0;
    end else if (s_size == `SIZE_BYTE) begin
      lane_u = ~s_addr[0];
      lane_l = s_addr[0];
    end else begin
      lane_u = 1'b1;
      lane_l = 1'b1;
    end
    sh      = {s_last - idx_d, 3'b000};
    shifted = s_wdata >> sh;
    if (s_wide && s_size != `SIZE_BYTE)
      sub_wdata = (s_size == `SIZE_LONG && idx_d == 2'h0) ?
                  s_wdata[31:16] : s_wdata[15:0];
    else
      sub_wdata = {shifted[7:0], shifted[7:0]};
    active = (state_d != ST_IDLE);
  end

  // read assembly: bytes or words shift in, first one ends up highest
  always @* begin
    rin     = s_ext ? din_s2_q : INT_RDATA_I;
    // an unused lane is never looked at
    rbyte   = (s_wide && s_addr[0]) ? rin[7:0] : rin[15:8];
    rdata_d = rdata_q;
    if (in_idle)
      rdata_d = 32'h0000_0000;
    else if (fin && !s_we) begin
      if (!s_wide || s_size == `SIZE_BYTE)
        rdata_d = {rdata_q[23:0], rbyte};
      else
        rdata_d = {rdata_q[15:0], rin};
    end
  end

  // sequencer and pins; request copies need no reset
  always @(posedge CLK_I) begin
    if (seq_rst) begin
      state_q                <= ST_IDLE;
      idx_q                  <= 2'h0;
      wcnt_q                 <= 2'h0;
      rdata_q                <= 32'h0000_0000;
      burst_open_q           <= 1'b0;
      REQ_ACK_O              <= 1'b0;
      REQ_RDATA_O            <= 32'h0000_0000;
      INT_MEM_STB_O          <= 1'b0;
      INT_PER_STB_O          <= 1'b0;
      INT_WE_O               <= 1'b0;
      INT_ADDR_O             <= 24'h00_0000;
      INT_WDATA_O            <= 16'h0000;
      INT_LANE_O             <= 2'h0;
      ADDR_O                 <= 24'h00_0000;
      READ_STROBE_N_O        <= 1'b1;
      UPPER_WRITE_STROBE_N_O <= 1'b1;
      LOWER_WRITE_STROBE_N_O <= 1'b1;
      DATA_O                 <= 16'h0000;
      DATA_OE_O              <= 2'h0;
    end else begin
      state_q   <= state_d;
      idx_q     <= idx_d;
      wcnt_q    <= wcnt_d;
      rdata_q   <= rdata_d;
      REQ_ACK_O <= done;
      if (done)
        REQ_RDATA_O <= rdata_d;
      if (in_idle && start) begin
        space_q <= REQ_SPACE_I;
        pwide_q <= REQ_PER_WIDE_I;
        area_q  <= REQ_AREA_I;
        addr_q  <= REQ_ADDR_I;
        size_q  <= REQ_SIZE_I;
        we_q    <= REQ_WRITE_I;
        fetch_q <= REQ_FETCH_I;
        wdata_q <= REQ_WDATA_I;
      end
      // a completed burst-space fetch leaves the burst open
      if (fin && s_ext) begin
        burst_open_q <= s_bsp & s_fetch;
        next_addr_q  <= ADDR_O + `WORD_STEP;
      end else if (!burst_rom_select_q)
        burst_open_q <= 1'b0;
      // internal side
      INT_MEM_STB_O <= active && (s_space == `SPACE_MEM);
      INT_PER_STB_O <= active && (s_space == `SPACE_PER);
      INT_WE_O      <= active && !s_ext && s_we;
      INT_LANE_O    <= active ? {lane_u, lane_l} : 2'h0;
      if (active && !s_ext) begin
        INT_ADDR_O  <= sub_addr;
        INT_WDATA_O <= sub_wdata;
      end
      // external side; strobes held for the whole access
      if (active && s_ext) begin
        ADDR_O <= sub_addr;
        DATA_O <= sub_wdata;
      end
      READ_STROBE_N_O        <= ~(active && s_ext && !s_we);
      UPPER_WRITE_STROBE_N_O <= ~(active && s_ext && s_we &&
                                  lane_u);
      LOWER_WRITE_STROBE_N_O <= ~(active && s_ext && s_we &&
                                  lane_l);
      // lanes not written stay undriven
      DATA_OE_O <= (active && s_ext && s_we) ? {lane_u, lane_l} :
                   2'h0;
    end
  end

  // register read mux
  always @* begin
    reg_rdata = 32'h0000_0000;
    if (AVS_ADDRESS_I == `OFS_ACCESS_STATE)
      reg_rdata[7:0] = access_state_q;
    else if (AVS_ADDRESS_I == `OFS_BUS_WIDTH)
      reg_rdata[7:0] = bus_width_q;
    else if (AVS_ADDRESS_I == `OFS_STALL_CTRL)
      reg_rdata[15:0] = stall_ctrl_q;
    else if (AVS_ADDRESS_I == `OFS_BUS_CTRL)
      reg_rdata[3:0] = {burst_word_count_select_q,
                        burst_cycle_length_select_q,
                        burst_rom_select_q, stall_pin_enable_q};
    else if (AVS_ADDRESS_I == `OFS_STATUS)
      reg_rdata[7:0] = {burst_open_q, idx_q, state_q,
                        ~in_idle, REQ_ACK_O};
  end

  // avalon slave: one wait cycle, then the access completes
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0000_0000;
    end else if (bus_req && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O    <= reg_rdata;
    end else
      AVS_WAITREQUEST_O <= 1'b1;
  end

  // configuration writes; the manual reset leaves these alone
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      access_state_q              <= `RST_ACCESS_STATE;
      bus_width_q                 <= BUS_WIDTH_INIT;
      stall_ctrl_q                <= `RST_STALL_CTRL;
      stall_pin_enable_q          <= BUS_CTRL_INIT[`BC_STALL_PIN_EN];
      burst_rom_select_q          <= BUS_CTRL_INIT[`BC_BURST_ROM];
      burst_cycle_length_select_q <= BUS_CTRL_INIT[`BC_BURST_LEN];
      burst_word_count_select_q   <= BUS_CTRL_INIT[`BC_BURST_WORDS];
    end else if (bus_wr) begin
      if (AVS_ADDRESS_I == `OFS_ACCESS_STATE) begin
        if (AVS_BYTEENABLE_I[0])
          access_state_q <= AVS_WRITEDATA_I[7:0];
      end else if (AVS_ADDRESS_I == `OFS_BUS_WIDTH) begin
        if (AVS_BYTEENABLE_I[0])
          bus_width_q <= AVS_WRITEDATA_I[7:0];
      end else if (AVS_ADDRESS_I == `OFS_STALL_CTRL) begin
        if (AVS_BYTEENABLE_I[0])
          stall_ctrl_q[7:0] <= AVS_WRITEDATA_I[7:0];
        if (AVS_BYTEENABLE_I[1])
          stall_ctrl_q[15:8] <= AVS_WRITEDATA_I[15:8];
      end else if (AVS_ADDRESS_I == `OFS_BUS_CTRL) begin
        if (AVS_BYTEENABLE_I[0]) begin
          stall_pin_enable_q <= AVS_WRITEDATA_I[`BC_STALL_PIN_EN];
          burst_rom_select_q <= AVS_WRITEDATA_I[`BC_BURST_ROM];
          burst_cycle_length_select_q <=
            AVS_WRITEDATA_I[`BC_BURST_LEN];
          burst_word_count_select_q <=
            AVS_WRITEDATA_I[`BC_BURST_WORDS];
        end
      end
    end
  end

endmodule

// >>> bench/ext_bus_ctrl_monitor.sv
// port-level assertions for the external bus controller
// assumes one clock and the map of ext_bus_defs.vh
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module ext_bus_ctrl_monitor #(
  parameter logic [7:0] BUS_WIDTH_INIT = 8'hFF
) (
  input logic        CLK_I,
  input logic        SRST_I,
  input logic [4:0]  AVS_ADDRESS_I,
  input logic        AVS_READ_I,
  input logic        AVS_WRITE_I,
  input logic [31:0] AVS_WRITEDATA_I,
  input logic        AVS_WAITREQUEST_O,
  input logic        REQ_I,
  input logic [1:0]  REQ_SPACE_I,
  input logic [2:0]  REQ_AREA_I,
  input logic [1:0]  REQ_SIZE_I,
  input logic        REQ_ACK_O,
  input logic        INT_MEM_STB_O,
  input logic        INT_PER_STB_O,
  input logic [23:0] ADDR_O,
  input logic        READ_STROBE_N_O,
  input logic        UPPER_WRITE_STROBE_N_O,
  input logic        LOWER_WRITE_STROBE_N_O,
  input logic [1:0]  DATA_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic [7:0] wid_q;
  logic       brst_q;
  wire        wr_u = !UPPER_WRITE_STROBE_N_O;
  wire        wr_l = !LOWER_WRITE_STROBE_N_O;
  wire        ext  = REQ_I && REQ_SPACE_I == `SPACE_EXT;
  // burst area 0 is always wide
  wire narrow = wid_q[REQ_AREA_I] && !(brst_q && REQ_AREA_I == `BURST_AREA);
  // shadow of width and burst bits, kept over manual reset
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      wid_q  <= BUS_WIDTH_INIT;
      brst_q <= 1'b0;
    end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O) begin
      if (AVS_ADDRESS_I == `OFS_BUS_WIDTH) wid_q <= AVS_WRITEDATA_I[7:0];
      if (AVS_ADDRESS_I == `OFS_BUS_CTRL)
        brst_q <= AVS_WRITEDATA_I[`BC_BURST_ROM];
    end
  end
  sequence s_per2;
    INT_PER_STB_O [*2] ##1 !INT_PER_STB_O;
  endsequence
  sequence s_wait1;
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  property p_mem_one;
    $rose(INT_MEM_STB_O) |=> !INT_MEM_STB_O;
  endproperty
  property p_per_two;
    $rose(INT_PER_STB_O) |-> s_per2;
  endproperty
  property p_wait_one;
    $rose(AVS_READ_I || AVS_WRITE_I) |-> s_wait1;
  endproperty
  property p_ack_pulse;
    REQ_ACK_O |-> REQ_I ##1 !REQ_ACK_O;
  endproperty
  property p_rd_float;
    !READ_STROBE_N_O |-> !wr_u && !wr_l && DATA_OE_O == 2'h0;
  endproperty
  property p_wr_oe;
    (wr_u || wr_l) |-> DATA_OE_O == {wr_u, wr_l};
  endproperty
  property p_narrow;
    ext && narrow |-> !wr_l && !DATA_OE_O[0];
  endproperty
  property p_byte_lane;
    ext && !narrow && REQ_SIZE_I == `SIZE_BYTE && (wr_u || wr_l)
      |-> wr_u == !ADDR_O[0] && wr_l == ADDR_O[0];
  endproperty
  property p_word_both;
    ext && !narrow && REQ_SIZE_I != `SIZE_BYTE && (wr_u || wr_l)
      |-> wr_u && wr_l;
  endproperty
  a_mem_one: assert property (p_mem_one)
    else $error("mem access not one state");
  a_per_two: assert property (p_per_two)
    else $error("periph access not two states");
  a_wait_one: assert property (p_wait_one)
    else $error("register wait cycle wrong");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not a single pulse");
  a_rd_float: assert property (p_rd_float)
    else $error("pins driven during read");
  a_wr_oe: assert property (p_wr_oe)
    else $error("lane drive not write strobes");
  a_narrow: assert property (p_narrow)
    else $error("narrow area used lower lane");
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte lane not address parity");
  a_word_both: assert property (p_word_both)
    else $error("word write missing a strobe");
endmodule

bind ext_bus_ctrl ext_bus_ctrl_monitor #(
  .BUS_WIDTH_INIT(BUS_WIDTH_INIT)
) i_mon (.*);

// >>> bench/ext_mem_model.sv
// behavioural external memory: 256 bytes, both lanes, stall pin
// assumes strobes and address come straight from the controller pins
`timescale 1ns/1ps
module ext_mem_model (
  input  logic        clk_i,
  input  logic [23:0] addr_i,
  input  logic        rd_n_i,
  input  logic        wu_n_i,
  input  logic        wl_n_i,
  input  logic [15:0] data_i,
  input  logic        narrow_i,
  input  int          stall_len_i,
  output logic [15:0] data_o,
  output logic        stall_n_o
);
  logic [7:0]  mem [256];
  logic [15:0] junk_q = 16'h0F0F;
  int          cnt_q = 0;
  wire  [7:0]  ev  = {addr_i[7:1], 1'b0};
  wire  [7:0]  od  = {addr_i[7:1], 1'b1};
  wire  [7:0]  up  = narrow_i ? addr_i[7:0] : ev;
  wire         act = !rd_n_i || !wu_n_i || !wl_n_i;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
  // idle lanes toggle so stale data never passes
  always @(posedge clk_i) begin
    junk_q <= ~junk_q;
    cnt_q  <= act ? cnt_q + 1 : 0;
    if (!wu_n_i) mem[up] <= data_i[15:8];
    if (!wl_n_i) mem[od] <= data_i[7:0];
  end
  assign data_o = rd_n_i ? junk_q : narrow_i ? {mem[up], junk_q[7:0]}
                                             : {mem[ev], mem[od]};
  // stall pin low for the first stall_len_i strobe cycles
  assign stall_n_o = !(act && cnt_q < stall_len_i);
endmodule

// >>> bench/tb_external_memory_bus_interface.sv
// self-checking bench for the external bus controller
// assumes the memory model on the pins and a fixed random seed
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module tb_external_memory_bus_interface;
  logic        clk = 0, srst = 1, mrst = 0, av_r = 0, av_w = 0;
  logic        req = 0, wide = 0, wr = 0, fetch = 0, narrow = 0;
  logic        ack, wreq, rd_n, wu_n, wl_n, stall_n;
  logic [4:0]  av_a = 0;
  logic [31:0] av_d = 0, wdat = 0, av_q, rdat;
  logic [1:0]  space = 0, size = 0, oe;
  logic [2:0]  area = 0;
  logic [23:0] addr = 0, int_a, pa;
  logic [15:0] po, pi;
  logic [7:0]  mem [256];
  int          n_errors = 0, check_count = 0, seed = 83276, slen = 0;
  always #5 clk = ~clk;
  ext_bus_ctrl #(.BUS_WIDTH_INIT(8'h0F)) i_dut (
    .CLK_I(clk), .SRST_I(srst), .MANUAL_RST_I(mrst),
    .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_r), .AVS_WRITE_I(av_w),
    .AVS_WRITEDATA_I(av_d), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(av_q), .AVS_WAITREQUEST_O(wreq), .REQ_I(req),
    .REQ_SPACE_I(space), .REQ_PER_WIDE_I(wide), .REQ_AREA_I(area),
    .REQ_ADDR_I(addr), .REQ_SIZE_I(size), .REQ_WRITE_I(wr),
    .REQ_FETCH_I(fetch), .REQ_WDATA_I(wdat), .REQ_ACK_O(ack),
    .REQ_RDATA_O(rdat), .INT_MEM_STB_O(), .INT_PER_STB_O(),
    .INT_WE_O(), .INT_ADDR_O(int_a), .INT_WDATA_O(), .INT_LANE_O(),
    .INT_RDATA_I(~int_a[15:0]), .ADDR_O(pa), .READ_STROBE_N_O(rd_n),
    .UPPER_WRITE_STROBE_N_O(wu_n), .LOWER_WRITE_STROBE_N_O(wl_n),
    .DATA_O(po), .DATA_OE_O(oe), .DATA_I(pi), .STALL_REQUEST_N_I(stall_n));
  ext_mem_model i_mem (.clk_i(clk), .addr_i(pa), .rd_n_i(rd_n),
    .wu_n_i(wu_n), .wl_n_i(wl_n), .data_i(po), .narrow_i(narrow),
    .stall_len_i(slen), .data_o(pi), .stall_n_o(stall_n));
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, lo, hi, input string m);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0d", $time, m, got);
    end
  endtask
  // register access, held until waitrequest is low
  task automatic av(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    av_a <= a;
    av_w <= w;
    av_r <= !w;
    av_d <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = av_q;
    av_r <= 0;
    av_w <= 0;
    if (n >= 50) chk(0, 1, "register bus hang");
  endtask
  // requester: lat counts edges from take to ack
  task automatic rq(input logic [1:0] s, input logic [2:0] ar,
                    input logic [23:0] ad, input logic [1:0] sz,
                    input logic w, f, output int lat);
    @(posedge clk);
    req <= 1;
    space <= s;
    area <= ar;
    addr <= ad;
    size <= sz;
    wr <= w;
    fetch <= f;
    @(posedge clk);
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (ack !== 1'b1 && lat < 300);
    req <= 0;
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] a,
                                         input logic [1:0] sz);
    exp_rd = 0;
    for (int i = 0; i < (1 << sz); i++)
      exp_rd = {exp_rd[23:0], mem[8'(a + i)]};
  endfunction
  function automatic int exp_lat(input logic [7:0] ast, wid,
    input logic [15:0] stl, input logic [2:0] a, input logic [1:0] sz);
    int st;
    st = ast[a] ? 3 + int'(stl[2 * a +: 2]) : 2;
    return (wid[a] ? (1 << sz) : (sz == 2 ? 2 : 1)) * st + 1;
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // the whole run needs well under 20k cycles
  initial begin
    #500_000;
    n_errors++;
    print_verdict();
  end
  initial begin
    logic [31:0] q;
    logic [15:0] stl;
    logic [7:0]  ast, wid, a8;
    logic [1:0]  sz;
    logic [2:0]  ar;
    logic        w;
    int          lat, nw;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
    repeat (12) @(posedge clk);
    srst <= 0;
    av(0, `OFS_ACCESS_STATE, 0, q);
    chk(q, 32'h0000_00FF, "state reset");
    av(0, `OFS_STALL_CTRL, 0, q);
    chk(q, 32'h0000_FFFF, "stall reset");
    av(0, `OFS_BUS_CTRL, 0, q);
    chk(q, 0, "control reset");
    av(0, `OFS_BUS_WIDTH, 0, q);
    chk(q, 32'h0000_000F, "width reset");
    av(0, 5'h14, 0, q);
    chk(q, 0, "unmapped");
    $display("test reset done");
    rq(`SPACE_MEM, 0, 24'h00_0010, `SIZE_WORD, 0, 0, lat);
    chk(lat, 2, "memory latency");
    chk(rdat[15:0], 16'hFFEF, "memory data");
    wide <= 1;
    rq(`SPACE_PER, 0, 24'h00_0020, `SIZE_WORD, 0, 0, lat);
    chk(lat, 3, "peripheral latency");
    $display("test internal done");
    // random area setups; the first two are fixed corners
    for (int k = 0; k < 8; k++) begin
      {ast, wid, stl} = $random(seed);
      if (k == 0) {ast, wid, stl} = 32'hFFFF_FFFF;
      if (k == 1) {ast, wid} = 16'h0000;
      av(1, `OFS_ACCESS_STATE, {24'h0, ast}, q);
      av(1, `OFS_BUS_WIDTH, {24'h0, wid}, q);
      av(1, `OFS_STALL_CTRL, {16'h0, stl}, q);
      for (int j = 0; j < 8; j++) begin
        {ar, a8, w} = $random(seed);
        sz = 2'({$random(seed)} % 3);
        if (sz != 0) a8[0] = 0;
        wdat <= $random(seed);
        slen = {$random(seed)} % 8;
        narrow = wid[ar];
        rq(`SPACE_EXT, ar, {16'h0, a8}, sz, w, 0, lat);
        chk(lat, exp_lat(ast, wid, stl, ar, sz),
            "external latency");
        if (w) for (int i = 0; i < (1 << sz); i++)
          mem[8'(a8 + i)] = 8'(wdat >> (8 * ((1 << sz) - 1 - i)));
        else if (ast[ar])
          chk(rdat, exp_rd(a8, sz), "external read");
      end
    end
    $display("test external done");
    av(1, `OFS_ACCESS_STATE, 32'h0000_00FF, q);
    av(1, `OFS_BUS_WIDTH, 0, q);
    av(1, `OFS_STALL_CTRL, 32'h0000_FFFF, q);
    slen = 6;
    narrow = 0;
    for (int e = 0; e < 4; e++) begin
      av(1, `OFS_BUS_CTRL, e & 1, q);
      rq(`SPACE_EXT, e[1] ? 3'h5 : 3'h2, 24'h00_0031, `SIZE_BYTE, 0, 0, lat);
      if (e[0]) chk_rng(lat, 10, 12, "pin stall");
      else chk(lat, 7, "pin ignored");
    end
    $display("test stall pin done");
    slen = 40;
    for (int c = 0; c < 4; c++) begin
      av(1, `OFS_ACCESS_STATE, c & 1, q);
      av(1, `OFS_BUS_WIDTH, 1, q);
      av(1, `OFS_BUS_CTRL, 3 | (c & 2) << 1 | (c & 1) << 3, q);
      nw = c[0] ? 8 : 4;
      for (int i = 0; i <= nw; i++) begin
        rq(`SPACE_EXT, 0, 24'h00_0040 + 2 * i, `SIZE_WORD, 0, 1, lat);
        if (i > 0 && i < nw)
          chk(lat, c[1] ? 3 : 2, "burst beat");
        else if (!c[0]) chk(lat, 3, "burst full cycle");
      end
      if (c == 0) begin
        rq(`SPACE_EXT, 0, 24'h00_0060, `SIZE_WORD, 0, 1, lat);
        rq(`SPACE_EXT, 0, 24'h00_0062, `SIZE_WORD, 0, 0, lat);
        chk(lat, 3, "data read not burst");
      end
    end
    $display("test burst done");
    av(1, `OFS_STALL_CTRL, 32'h0000_001B, q);
    @(posedge clk);
    mrst <= 1;
    @(posedge clk);
    mrst <= 0;
    repeat (4) @(posedge clk);
    av(0, `OFS_STALL_CTRL, 0, q);
    chk(q, 32'h0000_001B, "stall kept");
    av(0, `OFS_BUS_CTRL, 0, q);
    chk(q, 32'h0000_000F, "control kept");
    $display("test manual reset done");
    print_verdict();
  end
endmodule
